//--- eirqd_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the external
//          interrupt detector.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Included by the package and by the top module.
// Behaviour
// - Seven external interrupt inputs exist, each with its own enable and mode, set independently.
// - An edge mode sends one pulse to the interrupt controller on the chosen transition.
// - A level mode holds the request high while the chosen level stays on the input.
// - Detection runs in the always-on domain and a detected event can wake from hibernate.
// - Mode 000 is rising, 001 falling, 010 either edge, 011 high level, 100 low level.
// - Mode 101 acts as falling, 110 as either edge, 111 as high level.
// - An input makes requests only while its enable is 1, whatever its mode.
// - First config register holds int0 at [2:0]/3, int1 at [6:4]/7, int2 at [10:8]/11.
// - Second config register holds int4 at [2:0]/3, int5 at [6:4]/7, int7 at [14:12]/15.
// - Configuration registers reset to zero, so all inputs start disabled in rising mode.
// - Writing 1 to a clear register bit clears that input's flag; the bit returns to zero.
// - Third config register holds int8 mode at [2:0] and enable at bit 3.
`ifndef EIRQD_MAP_SVH
`define EIRQD_MAP_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define EIRQD_ADDR_CFG_FIRST 32'h4000_2420
`define EIRQD_ADDR_CFG_SECOND 32'h4000_2424
`define EIRQD_ADDR_CFG_THIRD 32'h4000_2428
`define EIRQD_ADDR_FLAG_CLEAR 32'h4000_2430
`define EIRQD_ADDR_STATUS 32'h4000_2434

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define EIRQD_FIELD_W 4
`define EIRQD_MODE_W 3
`define EIRQD_EN_BIT 3
`define EIRQD_REG_W 16
`define EIRQD_CFG_RESET 16'h0000
`define EIRQD_CFG_THIRD_MASK 16'h000F
`define EIRQD_CFG_SECOND_MASK 16'hF0FF
`define EIRQD_CFG_FIRST_MASK 16'h0FFF
`define EIRQD_CLEAR_MASK 16'h01B7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EIRQD_SYNC_STAGES 2
`define EIRQD_WAIT_CYCLES 1

`endif

//--- eirqd_pkg.sv
// Purpose: Types shared by the external interrupt detector.
// Assumes: eirqd_map.svh holds the numbers.
// Notes:   Mode codes include the aliases.
package eirqd_pkg;
`include "eirqd_map.svh"

	typedef enum logic [2:0]
	{
		EIRQD_RISE = 3'h0,
		EIRQD_FALL = 3'h1,
		EIRQD_BOTH = 3'h2,
		EIRQD_HIGH = 3'h3,
		EIRQD_LOW = 3'h4,
		EIRQD_FALL_ALIAS = 3'h5,
		EIRQD_BOTH_ALIAS = 3'h6,
		EIRQD_HIGH_ALIAS = 3'h7
	} eirqd_mode_e;

	typedef struct packed
	{
		logic enable;
		eirqd_mode_e mode;
	} eirqd_cfg_s;

	typedef struct packed
	{
		logic read;
		logic write;
		logic [31:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} eirqd_req_s;

	typedef enum
	{
		EIRQD_IDLE,
		EIRQD_ACK
	} eirqd_state_e;
endpackage

//--- eirqd_detect.sv
// Purpose: Seven-input external interrupt detector with Avalon-MM configuration.
// Assumes: Always-on core clock at 10 MHz, synchronous active-high reset.
// Notes:   Input index 0..8 with 3 and 6 absent; absent lanes are tied off.
`timescale 1ns/100ps
`include "eirqd_map.svh"

module eirqd_detect
	import eirqd_pkg::*;
#(
	parameter int NUM_LANES = 9
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] address,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	// External pins, after the pin input path
	input wire logic [NUM_LANES-1:0] extPin,
	// Requests toward the interrupt controller
	output logic [NUM_LANES-1:0] irqRequest,
	output logic wakeRequest,
	output logic [NUM_LANES-1:0] irqFlag
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] be, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (be[0])
		begin
			v[7:0] = data[7:0];
		end
		if (be[1])
		begin
			v[15:8] = data[15:8];
		end
		return v & mask;
	endfunction

	function automatic eirqd_cfg_s laneCfg(input logic [15:0] reg16, input int slot);
		eirqd_cfg_s c;
		c.enable = reg16[slot*`EIRQD_FIELD_W + `EIRQD_EN_BIT];
		c.mode = eirqd_mode_e'(reg16[slot*`EIRQD_FIELD_W +: `EIRQD_MODE_W]);
		return c;
	endfunction

	// Full-word compare, so an alias of a register reads as unmapped
	function automatic logic addrIs(input logic [31:0] a, input logic [31:0] target);
		return a == target;
	endfunction

	// Bit 1 is the edge pulse, bit 0 the level hit, both held off by a clear enable
	function automatic logic [1:0] laneDetect(input eirqd_cfg_s c, input logic pinLevel,
		input logic upEdge, input logic downEdge);
		logic edgeHit;
		logic levelOn;
		edgeHit = 1'b0;
		levelOn = 1'b0;
		case (c.mode)
			EIRQD_RISE:
			begin
				edgeHit = upEdge;
			end
			EIRQD_FALL, EIRQD_FALL_ALIAS:
			begin
				edgeHit = downEdge;
			end
			EIRQD_BOTH, EIRQD_BOTH_ALIAS:
			begin
				edgeHit = upEdge | downEdge;
			end
			EIRQD_HIGH, EIRQD_HIGH_ALIAS:
			begin
				levelOn = pinLevel;
			end
			EIRQD_LOW:
			begin
				levelOn = ~pinLevel;
			end
			default:
			begin
				edgeHit = 1'b0;
			end
		endcase
		return {edgeHit & c.enable, levelOn & c.enable};
	endfunction

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	eirqd_req_s req;
	eirqd_state_e state;
	eirqd_state_e next_state;
	logic [15:0] cfgFirst;
	logic [15:0] cfgSecond;
	logic [15:0] cfgThird;
	logic [15:0] flagClear;
	logic [31:0] next_readdata;
	logic [1:0] next_response;

	assign req = '{read: read, write: write, address: address, byteenable: byteenable,
		writedata: writedata};

	wire logic access = (req.read | req.write) && (state == EIRQD_IDLE);
	wire logic hitFirst = addrIs(req.address, `EIRQD_ADDR_CFG_FIRST);
	wire logic hitSecond = addrIs(req.address, `EIRQD_ADDR_CFG_SECOND);
	wire logic hitThird = addrIs(req.address, `EIRQD_ADDR_CFG_THIRD);
	wire logic hitClear = addrIs(req.address, `EIRQD_ADDR_FLAG_CLEAR);
	wire logic hitStatus = addrIs(req.address, `EIRQD_ADDR_STATUS);
	wire logic hitAny = hitFirst | hitSecond | hitThird | hitClear | hitStatus;
	wire logic takeWrite = access & req.write;
	// Writes land at the edge where the master sees waitrequest low, not earlier
	wire logic doWrite = req.write && (state == EIRQD_ACK);

	// One wait cycle: request accepted on the second edge
	always_comb
	begin
		next_state = EIRQD_IDLE;
		case (state)
			EIRQD_IDLE:
			begin
				next_state = access ? EIRQD_ACK : EIRQD_IDLE;
			end
			EIRQD_ACK:
			begin
				next_state = EIRQD_IDLE;
			end
			default:
			begin
				next_state = EIRQD_IDLE;
			end
		endcase
	end

	// Low only in the ack cycle, and low when idle with no request
	assign waitrequest = (read | write) && (state != EIRQD_ACK);

	always_comb
	begin
		next_readdata = readdata;
		next_response = response;
		if (access & req.read)
		begin
			next_readdata = 32'h0000_0000;
			next_response = hitAny ? 2'h0 : 2'h2;
			if (hitFirst)
			begin
				next_readdata = {16'h0000, cfgFirst};
			end
			if (hitSecond)
			begin
				next_readdata = {16'h0000, cfgSecond};
			end
			if (hitThird)
			begin
				next_readdata = {16'h0000, cfgThird};
			end
			if (hitClear)
			begin
				next_readdata = {16'h0000, flagClear};
			end
			if (hitStatus)
			begin
				next_readdata = 32'(irqFlag);
			end
		end
		else if (takeWrite)
		begin
			next_response = hitAny ? 2'h0 : 2'h2;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state <= EIRQD_IDLE;
			readdata <= 32'h0000_0000;
			response <= 2'h0;
		end
		else
		begin
			state <= next_state;
			readdata <= next_readdata;
			response <= next_response;
		end
	end

	// Configuration registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			cfgFirst <= `EIRQD_CFG_RESET;
			cfgSecond <= `EIRQD_CFG_RESET;
			cfgThird <= `EIRQD_CFG_RESET;
		end
		else if (doWrite)
		begin
			if (hitFirst)
			begin
				cfgFirst <= merge16(cfgFirst, writedata, byteenable, `EIRQD_CFG_FIRST_MASK);
			end
			if (hitSecond)
			begin
				cfgSecond <= merge16(cfgSecond, writedata, byteenable,
					`EIRQD_CFG_SECOND_MASK);
			end
			if (hitThird)
			begin
				cfgThird <= merge16(cfgThird, writedata, byteenable, `EIRQD_CFG_THIRD_MASK);
			end
		end
	end

	// Clear bits last one cycle, then fall back by themselves
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			flagClear <= `EIRQD_CFG_RESET;
		end
		else if (doWrite && hitClear)
		begin
			flagClear <= merge16(16'h0000, writedata, byteenable, `EIRQD_CLEAR_MASK);
		end
		else
		begin
			flagClear <= 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Lane configuration map
	// ----------------------------------------------------------------
	eirqd_cfg_s cfg [NUM_LANES];

	assign cfg[0] = laneCfg(cfgFirst, 0);
	assign cfg[1] = laneCfg(cfgFirst, 1);
	assign cfg[2] = laneCfg(cfgFirst, 2);
	assign cfg[3] = '{enable: 1'b0, mode: EIRQD_RISE};
	assign cfg[4] = laneCfg(cfgSecond, 0);
	assign cfg[5] = laneCfg(cfgSecond, 1);
	assign cfg[6] = '{enable: 1'b0, mode: EIRQD_RISE};
	assign cfg[7] = laneCfg(cfgSecond, 3);
	assign cfg[8] = laneCfg(cfgThird, 0);

	// ----------------------------------------------------------------
	// Synchroniser and detection
	// ----------------------------------------------------------------
	logic [NUM_LANES-1:0] syncMeta;
	logic [NUM_LANES-1:0] syncPin;
	logic [NUM_LANES-1:0] prevPin;
	logic [NUM_LANES-1:0] edgePulse;
	logic [NUM_LANES-1:0] levelHit;
	logic [NUM_LANES-1:0] next_irqFlag;

	// Pins are asynchronous; first stage feeds only the second
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			syncMeta <= '0;
			syncPin <= '0;
			prevPin <= '0;
		end
		else
		begin
			syncMeta <= extPin;
			syncPin <= syncMeta;
			prevPin <= syncPin;
		end
	end

	wire logic [NUM_LANES-1:0] rise = syncPin & ~prevPin;
	wire logic [NUM_LANES-1:0] fall = ~syncPin & prevPin;

	// Each lane decodes only its own field
	always_comb
	begin
		for (int i = 0; i < NUM_LANES; i++)
		begin
			{edgePulse[i], levelHit[i]} = laneDetect(cfg[i], syncPin[i], rise[i], fall[i]);
		end
	end

	// Sticky flag: a new event wins over a clear in the same cycle
	assign next_irqFlag = (irqFlag & ~flagClear[NUM_LANES-1:0]) | edgePulse | levelHit;

	// ----------------------------------------------------------------
	// Requests, flags and wake
	// ----------------------------------------------------------------
	wire logic [NUM_LANES-1:0] laneEvent = edgePulse | levelHit;

	// Edge gives one-cycle pulse, level follows the pin
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			irqRequest <= '0;
		end
		else
		begin
			irqRequest <= laneEvent;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			irqFlag <= '0;
		end
		else
		begin
			irqFlag <= next_irqFlag;
		end
	end

	// Clock stays on in always-on domain, so wake rides the same event
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			wakeRequest <= 1'b0;
		end
		else
		begin
			wakeRequest <= |laneEvent;
		end
	end

endmodule

//--- eirqd_detect_sva.sv
// Purpose: Port-level checks of the external interrupt detector.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every eirqd_detect.
`timescale 1ns/100ps
`include "eirqd_map.svh"
module eirqd_detect_sva
	import eirqd_pkg::*;
#(
	parameter int NUM_LANES = 9
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Avalon-MM
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] address,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic [1:0] response,
	// Pins and requests
	input wire logic [NUM_LANES-1:0] extPin,
	input wire logic [NUM_LANES-1:0] irqRequest,
	input wire logic wakeRequest,
	input wire logic [NUM_LANES-1:0] irqFlag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	logic cfgTouched;
	logic [NUM_LANES-1:0] clrBits;
	assign clrBits = (write && !waitrequest && address == `EIRQD_ADDR_FLAG_CLEAR) ?
		writedata[NUM_LANES-1:0] : '0;
	// Any config write, even unmapped, only weakens the check
	always_ff @(posedge clock)
		cfgTouched <= !reset && (cfgTouched || (write && !waitrequest &&
			address < `EIRQD_ADDR_FLAG_CLEAR));
	sequence s_rd(logic [31:0] a);
		read && !waitrequest && address == a;
	endsequence
	sequence s_still;
		(!write && !$past(reset) && $stable(extPin)) [*5];
	endsequence
	property p_absent; (irqRequest[3] | irqRequest[6] | irqFlag[3] | irqFlag[6]) == 1'b0; endproperty
	a_absent: assert property (p_absent) else $error("absent lane fired");
	property p_wake; wakeRequest == (|irqRequest); endproperty
	a_wake: assert property (p_wake) else $error("wake differs from requests");
	property p_start_off; !cfgTouched |-> irqRequest == '0; endproperty
	a_start_off: assert property (p_start_off) else $error("request before enable");
	property p_flag_set; (irqRequest & ~irqFlag) == '0; endproperty
	a_flag_set: assert property (p_flag_set) else $error("event without flag");
	property p_flag_drop; $past(reset) || ($past(irqFlag) & ~irqFlag & ~$past(clrBits, 2)) == '0;
	endproperty
	a_flag_drop: assert property (p_flag_drop) else $error("flag dropped unasked");
	property p_first; s_rd(`EIRQD_ADDR_CFG_FIRST) |-> readdata[31:12] == 20'h0_0000; endproperty
	a_first: assert property (p_first) else $error("reserved bits set");
	property p_second; s_rd(`EIRQD_ADDR_CFG_SECOND) |-> readdata[11:8] == 4'h0; endproperty
	a_second: assert property (p_second) else $error("reserved bits set");
	property p_still; s_still |=> $stable(irqRequest); endproperty
	a_still: assert property (p_still) else $error("request moved, pins still");
endmodule
bind eirqd_detect eirqd_detect_sva #(.NUM_LANES(NUM_LANES)) chk_u (.clock(clock), .reset(reset),
	.read(read), .write(write), .address(address), .byteenable(byteenable),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.response(response), .extPin(extPin), .irqRequest(irqRequest),
	.wakeRequest(wakeRequest), .irqFlag(irqFlag));

//--- eirqd_pin_model.sv
// Purpose: External pins feeding the detector.
// Assumes: Bench asks for a level per pin each cycle.
// Notes:   Pins move off the clock edge, like asynchronous sources.
`timescale 1ns/100ps
module eirqd_pin_model
#(
	parameter int SKEW = 37
)
(
	input wire logic clock,
	input wire logic [8:0] drive,
	input wire logic [8:0] pathEnable,
	output logic [8:0] extPin
);
	logic [8:0] held = 9'h000;
	// Latched per edge, so each level lasts a full cycle
	always @(posedge clock)
		held <= #SKEW drive;
	// Closed input path reads as pulled down
	assign extPin = held & pathEnable;
endmodule

//--- eirqd_tb.sv
// Purpose: Random and corner tests of the external interrupt detector.
// Assumes: Pins reach the block through the pin model.
// Notes:   Request checks pause around config writes; pins stay still then.
`timescale 1ns/100ps
`include "eirqd_map.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb
	import eirqd_pkg::*;
;
	logic clock = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, watch = 1'b0;
	logic waitrequest, wakeRequest;
	logic [1:0] response, rsp;
	logic [31:0] address = 32'h0000_0000, writedata = 32'h0000_0000, readdata, q;
	logic [8:0] drive = 9'h000, pathEnable = 9'h1FF, extPin, irqRequest, irqFlag, expReq;
	logic [8:0] expFlag = 9'h000;
	logic [3:0][8:0] hist;
	eirqd_cfg_s mirror [9];
	int n_mismatch = 0, comparisons = 0;
	eirqd_detect #(.NUM_LANES(9)) dut_u (.clock(clock), .reset(reset), .read(read),
		.write(write), .address(address), .byteenable(4'hF), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .response(response),
		.extPin(extPin), .irqRequest(irqRequest), .wakeRequest(wakeRequest), .irqFlag(irqFlag));
	eirqd_pin_model pins_u (.clock(clock), .drive(drive), .pathEnable(pathEnable), .extPin(extPin));
	initial
		forever #50 clock = ~clock;
	function automatic logic hit(eirqd_cfg_s c, logic nw, logic od);
		case (c.mode)
			EIRQD_RISE: hit = nw & ~od;
			EIRQD_FALL, EIRQD_FALL_ALIAS: hit = ~nw & od;
			EIRQD_BOTH, EIRQD_BOTH_ALIAS: hit = nw ^ od;
			EIRQD_LOW: hit = ~nw;
			default: hit = nw;
		endcase
		hit = hit & c.enable;
	endfunction
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
		int n;
		@(posedge clock);
		read <= ~w;
		write <= w;
		address <= a;
		writedata <= {16'h0000, d};
		for (n = 0; n < 20; n++)
		begin
			@(posedge clock);
			if (waitrequest === 1'b0)
				break;
		end
		q = readdata;
		rsp = response;
		read <= 1'b0;
		write <= 1'b0;
		if (n == 20)
		begin
			n_mismatch++;
			complete_run();
		end
	endtask
	task automatic set_cfg(input int r, input logic [15:0] d);
		logic [15:0] m;
		m = (r == 0) ? 16'h0FFF : (r == 1) ? 16'hF0FF : 16'h000F;
		watch <= 1'b0;
		acc(1'b1, 32'h4000_2420 + 4 * r, d);
		for (int f = 0; f < 4; f++)
			if (4 * r + f < 9)
				mirror[4 * r + f] = eirqd_cfg_s'(d[4 * f +: 4] & m[4 * f +: 4]);
		acc(1'b0, 32'h4000_2420 + 4 * r, 16'h0000);
		`CHK("cfg readback", {16'h0000, d & m}, q)
		repeat (2) @(posedge clock);
	endtask
	// Expected requests from pin samples three and four edges back
	always @(posedge clock)
	begin
		for (int i = 0; i < 9; i++)
			expReq[i] = hit(mirror[i], hist[2][i], hist[3][i]);
		if (watch)
		begin
			`CHK("irqRequest", expReq, irqRequest)
			`CHK("wakeRequest", |expReq, wakeRequest)
			expFlag = expFlag | expReq;
		end
		hist <= {hist[2:0], extPin};
	end
	initial
	begin
		for (int i = 0; i < 9; i++)
			mirror[i] = eirqd_cfg_s'(4'h0);
		void'($urandom(1641));
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		for (int r = 0; r < 4; r++)
		begin
			acc(1'b0, (r == 3) ? 32'h4000_2430 : 32'h4000_2420 + 4 * r, 16'h0000);
			`CHK("reset value", 32'h0000_0000, q)
		end
		acc(1'b0, 32'h4000_2438, 16'hFFFF);
		`CHK("unmapped response", 2'h2, rsp)
		for (int t = 0; t < 40; t++)
		begin
			for (int r = 0; r < 3; r++)
				set_cfg(r, (t < 8) ? {4{1'b1, 3'(t)}} : 16'($urandom));
			watch <= 1'b1;
			pathEnable <= (t < 8) ? 9'h1FF : 9'($urandom) | 9'h0F0;
			repeat (30)
			begin
				@(posedge clock);
				drive <= 9'($urandom);
			end
			repeat (6) @(posedge clock);
		end
		for (int r = 0; r < 3; r++)
			set_cfg(r, 16'h0000);
		watch <= 1'b1;
		`CHK("flags held", expFlag, irqFlag)
		acc(1'b1, 32'h4000_2430, 16'h0005);
		expFlag = expFlag & ~9'h005;
		repeat (2) @(posedge clock);
		`CHK("flags cleared", expFlag, irqFlag)
		acc(1'b0, 32'h4000_2430, 16'h0000);
		`CHK("clear readback", 32'h0000_0000, q)
		acc(1'b1, 32'h4000_2430, 16'hFFFF);
		repeat (2) @(posedge clock);
		`CHK("flags all clear", 9'h000, irqFlag)
		complete_run();
	end
endmodule
